// >>> rtl/vgaac_fifo.sv
// small synchronous fifo with registered read data
`timescale 1ns/1ns
module vgaac_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             out_valid_reg;
    logic             push;
    logic             pop_mem;

    // one word sits in the output register, the rest in memory
    assign in_ready  = (count_reg != (AW+1)'(DEPTH)) || pop_mem;
    assign push      = in_valid && in_ready;
    assign pop_mem   = (count_reg != '0) && (!out_valid_reg || out_ready);
    assign out_valid = out_valid_reg;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            out_valid_reg <= 1'b0;
            out_data      <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop_mem) begin
                rd_ptr_reg    <= rd_ptr_reg + 1'b1;
                out_data      <= mem[rd_ptr_reg];
                out_valid_reg <= 1'b1;
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop_mem);
        end
    end
endmodule

// >>> rtl/vgaac_pkg.sv
// shared constants and types for the vga attribute controller
package vgaac_pkg;
    // i/o locations (byte addresses of the legacy port space)
    localparam logic [15:0] VGAAC_IDX_PORT       = 16'h03c0;
    localparam logic [15:0] VGAAC_RD_PORT        = 16'h03c1;
    // internal register indices
    localparam logic [4:0]  VGAAC_PAL_LAST       = 5'h0f;
    localparam logic [4:0]  VGAAC_MODE_IDX       = 5'h10;
    localparam logic [4:0]  VGAAC_BORDER_IDX     = 5'h11;
    localparam logic [4:0]  VGAAC_PLANE_IDX      = 5'h12;
    localparam logic [4:0]  VGAAC_PAN_IDX        = 5'h13;
    localparam logic [4:0]  VGAAC_CSEL_IDX       = 5'h14;
    // field positions
    localparam int          VGAAC_IDX_SRC_BIT    = 5;
    localparam int          VGAAC_MODE_GRPH_BIT  = 0;
    localparam int          VGAAC_MODE_MONO_BIT  = 1;
    localparam int          VGAAC_MODE_LGRPH_BIT = 2;
    localparam int          VGAAC_MODE_BLINK_BIT = 3;
    localparam int          VGAAC_MODE_PANTOP_BIT = 5;
    localparam int          VGAAC_MODE_PACK_BIT  = 6;
    localparam int          VGAAC_MODE_CSEL_BIT  = 7;
    // reset values
    localparam logic [7:0]  VGAAC_REG_RST        = 8'h00;
    localparam logic [5:0]  VGAAC_PAL_RST        = 6'h00;
    localparam logic [1:0]  VGAAC_BLINK_RST      = 2'h0;
    // blink period, in frames, for code 0; code n gives (n+1) times that
    localparam logic [7:0]  VGAAC_BLINK_BASE     = 8'h10;
    // fifo shape
    localparam int          VGAAC_FIFO_W         = 9;
    localparam int          VGAAC_FIFO_D         = 16;
    // shared-location pointer state
    typedef enum logic [0:0] {
        VGAAC_PTR_INDEX = 1'b0,
        VGAAC_PTR_DATA  = 1'b1
    } vgaac_ptr_t;
endpackage

// >>> rtl/vgaac_top.sv
// vga attribute controller: host registers and pixel colour path
`timescale 1ns/1ns
module vgaac_top
    import vgaac_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // host i/o
    input  wire logic [15:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    input  wire logic       status_one_rd,
    output logic      [7:0] io_rdata,
    output logic      [1:0] status_mux_bits,
    // blink rate setting from the extended crtc control
    input  wire logic [1:0] blink_rate_code,
    // pixel input stream
    input  wire logic       pix_valid,
    output logic            pix_ready,
    input  wire logic [7:0] pix_data,
    input  wire logic       pix_active,
    input  wire logic       pix_top_half,
    input  wire logic       pix_line_gfx_col,
    input  wire logic       pix_cursor_on,
    input  wire logic       frame_start,
    // colour index output
    output logic            color_valid,
    input  wire logic       color_ready,
    output logic      [7:0] color_index,
    output logic      [3:0] pan_shift
);
    vgaac_ptr_t  ptr_reg;
    logic [4:0]  attr_register_pointer;
    logic        palette_source_select;
    logic [5:0]  palette_color_bits [16];
    logic [7:0]  mode_reg;
    logic [7:0]  border_color_value;
    logic [3:0]  plane_output_enables;
    logic [1:0]  status_mux_select;
    logic [3:0]  pixel_shift_count;
    logic [1:0]  low_color_override_bits;
    logic [1:0]  high_color_index_bits;
    logic [7:0]  blink_cnt_reg;
    logic        blink_phase_reg;
    logic [7:0]  blink_period;
    logic        wr_shared;
    logic        data_wr;
    logic [8:0]  fifo_in;
    logic [8:0]  fifo_out;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [7:0]  color_next;
    logic        color_valid_reg;
    logic [7:0]  last_color_reg;

    wire logic graphics_decode_select    = mode_reg[VGAAC_MODE_GRPH_BIT];
    wire logic monochrome_select         = mode_reg[VGAAC_MODE_MONO_BIT];
    wire logic line_graphics_enable      = mode_reg[VGAAC_MODE_LGRPH_BIT];
    wire logic blink_or_intensity_select = mode_reg[VGAAC_MODE_BLINK_BIT];
    wire logic pan_top_half_only         = mode_reg[VGAAC_MODE_PANTOP_BIT];
    wire logic packed_pixel_clocking     = mode_reg[VGAAC_MODE_PACK_BIT];
    wire logic alternate_color_source    = mode_reg[VGAAC_MODE_CSEL_BIT];

    function automatic logic is_port(input logic [15:0] a,
                                     input logic [15:0] p);
        is_port = (a == p);
    endfunction

    assign wr_shared = io_wr && is_port(io_addr, VGAAC_IDX_PORT);
    assign data_wr   = wr_shared && (ptr_reg == VGAAC_PTR_DATA);

    // pointer toggles on every shared write; a status read wins over it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_reg <= VGAAC_PTR_INDEX;
        end else if (status_one_rd) begin
            ptr_reg <= VGAAC_PTR_INDEX;
        end else if (wr_shared) begin
            ptr_reg <= vgaac_ptr_t'(~ptr_reg);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            attr_register_pointer <= '0;
            palette_source_select <= 1'b0;
        end else if (wr_shared && ptr_reg == VGAAC_PTR_INDEX) begin
            attr_register_pointer <= io_wdata[4:0];
            palette_source_select <= io_wdata[VGAAC_IDX_SRC_BIT];
        end
    end

    // palette writes accepted only while the host owns the palette
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_pal
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    palette_color_bits[gi] <= VGAAC_PAL_RST;
                end else if (data_wr && !palette_source_select
                             && attr_register_pointer == 5'(gi)) begin
                    palette_color_bits[gi] <= io_wdata[5:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg                <= VGAAC_REG_RST;
            border_color_value      <= VGAAC_REG_RST;
            plane_output_enables    <= '0;
            status_mux_select       <= '0;
            pixel_shift_count       <= '0;
            low_color_override_bits <= '0;
            high_color_index_bits   <= '0;
        end else if (data_wr) begin
            case (attr_register_pointer)
                VGAAC_MODE_IDX: begin
                    mode_reg <= {io_wdata[7:5], 1'b0, io_wdata[3:0]};
                end
                VGAAC_BORDER_IDX: begin
                    border_color_value <= io_wdata;
                end
                VGAAC_PLANE_IDX: begin
                    plane_output_enables <= io_wdata[3:0];
                    status_mux_select    <= io_wdata[5:4];
                end
                VGAAC_PAN_IDX: begin
                    pixel_shift_count <= io_wdata[3:0];
                end
                VGAAC_CSEL_IDX: begin
                    low_color_override_bits <= io_wdata[1:0];
                    high_color_index_bits   <= io_wdata[3:2];
                end
                default: begin
                end
            endcase
        end
    end

    // read-back of the selected register; unmapped indices read zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            io_rdata <= '0;
        end else if (io_rd && is_port(io_addr, VGAAC_RD_PORT)) begin
            if (attr_register_pointer <= VGAAC_PAL_LAST) begin
                io_rdata <= {2'b00,
                    palette_color_bits[attr_register_pointer[3:0]]};
            end else begin
                case (attr_register_pointer)
                    VGAAC_MODE_IDX:   io_rdata <= mode_reg;
                    VGAAC_BORDER_IDX: io_rdata <= border_color_value;
                    VGAAC_PLANE_IDX:  io_rdata <= {2'b00, status_mux_select,
                                                   plane_output_enables};
                    VGAAC_PAN_IDX:    io_rdata <= {4'h0, pixel_shift_count};
                    VGAAC_CSEL_IDX:   io_rdata <= {4'h0,
                        high_color_index_bits, low_color_override_bits};
                    default:          io_rdata <= 8'h00;
                endcase
            end
        end else if (io_rd && is_port(io_addr, VGAAC_IDX_PORT)) begin
            io_rdata <= {2'b00, palette_source_select,
                         attr_register_pointer};
        end
    end

    // blink timer counts frames; period is base times (code + 1)
    assign blink_period = VGAAC_BLINK_BASE * ({6'h00, blink_rate_code}
                          + 8'h01);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            blink_cnt_reg   <= '0;
            blink_phase_reg <= 1'b0;
        end else if (frame_start) begin
            if (blink_cnt_reg >= blink_period - 8'h01) begin
                blink_cnt_reg   <= '0;
                blink_phase_reg <= ~blink_phase_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 8'h01;
            end
        end
    end

    // the fifo decouples the pixel source from the output stage
    assign fifo_in = {pix_active, pix_data};

    vgaac_fifo #(
        .WIDTH (VGAAC_FIFO_W),
        .DEPTH (VGAAC_FIFO_D)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (pix_valid),
        .in_ready  (pix_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    assign fifo_pop    = !color_valid_reg || color_ready;
    assign color_valid = color_valid_reg;

    // pixel to colour index; cursor and ninth-column flags are sampled at the pop,
    // so the source must hold them steady relative to its stream
    always_comb begin
        logic [7:0] a;
        logic [3:0] val;
        logic [5:0] pal;
        logic       blink_off;
        a         = fifo_out[7:0];
        val       = 4'h0;
        pal       = 6'h00;
        blink_off = 1'b0;
        if (graphics_decode_select) begin
            val = a[3:0] & plane_output_enables;
        end else begin
            blink_off = blink_or_intensity_select && a[7]
                        && blink_phase_reg;
            // ninth column shows background unless line graphics is on
            if (pix_cursor_on && !blink_off
                && (line_graphics_enable || !pix_line_gfx_col)) begin
                val = a[3:0];
            end else begin
                val = a[7:4];
                if (blink_or_intensity_select) begin
                    val[3] = 1'b0;
                end
            end
            if (monochrome_select) begin
                val = {val[3], 1'b0, val[0] | val[1], 1'b0};
            end
            val = val & plane_output_enables;
        end
        pal = palette_source_select ? palette_color_bits[val]
                                    : 6'h00;
        if (alternate_color_source) begin
            pal[5:4] = low_color_override_bits;
        end
        color_next = {high_color_index_bits, pal};
        if (packed_pixel_clocking) begin
            color_next = palette_source_select ? a : 8'h00;
        end
        if (!fifo_out[8]) begin
            color_next = border_color_value;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            color_valid_reg <= 1'b0;
            color_index     <= '0;
            last_color_reg  <= '0;
        end else if (fifo_pop) begin
            color_valid_reg <= fifo_valid;
            if (fifo_valid) begin
                color_index    <= color_next;
                last_color_reg <= color_next;
            end
        end
    end

    // pan counts above 8 give zero shift; top-half-only drops panning below midline
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pan_shift <= '0;
        end else if (pan_top_half_only && !pix_top_half) begin
            pan_shift <= 4'h0;
        end else if (pixel_shift_count > 4'h8) begin
            pan_shift <= 4'h0;
        end else if (packed_pixel_clocking) begin
            pan_shift <= {1'b0, pixel_shift_count[3:1]};
        end else begin
            pan_shift <= pixel_shift_count;
        end
    end

    // status bit pair chosen from the last colour index
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_mux_bits <= '0;
        end else begin
            case (status_mux_select)
                2'h0:    status_mux_bits <= {last_color_reg[2],
                                             last_color_reg[0]};
                2'h1:    status_mux_bits <= last_color_reg[5:4];
                2'h2:    status_mux_bits <= {last_color_reg[3],
                                             last_color_reg[1]};
                2'h3:    status_mux_bits <= last_color_reg[7:6];
                default: status_mux_bits <= '0;
            endcase
        end
    end

    a_status_read_index: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        status_one_rd |=> ptr_reg == VGAAC_PTR_INDEX)
        else $error("pointer not back at index after status read");

    a_ptr_toggle_write: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wr_shared && !status_one_rd |=> ptr_reg != $past(ptr_reg))
        else $error("pointer did not toggle on shared write");

    sequence s_idx_wr;
        wr_shared && ptr_reg == VGAAC_PTR_INDEX && !status_one_rd;
    endsequence
    a_index_capture: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        s_idx_wr |=> attr_register_pointer == $past(io_wdata[4:0])
                     && ptr_reg == VGAAC_PTR_DATA)
        else $error("index write not captured");

    a_border_outside: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        fifo_pop && fifo_valid && !fifo_out[8]
        |=> color_index == $past(border_color_value))
        else $error("border colour not shown outside display");

    a_high_bits_csel: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        fifo_pop && fifo_valid && fifo_out[8] && !packed_pixel_clocking
        |=> color_index[7:6] == $past(high_color_index_bits))
        else $error("P7:P6 not from colour select");

    a_alt_source: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        fifo_pop && fifo_valid && fifo_out[8] && alternate_color_source
        && !packed_pixel_clocking
        |=> color_index[5:4] == $past(low_color_override_bits))
        else $error("P5:P4 override not applied");

    a_status_mux_p76: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        status_mux_select == 2'h3 |=> status_mux_bits ==
            $past(last_color_reg[7:6]))
        else $error("status mux pair wrong");

    a_pan_bottom_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        pan_top_half_only && !pix_top_half |=> pan_shift == 4'h0)
        else $error("panning applied below top half");

    a_blink_period: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        frame_start && blink_cnt_reg == blink_period - 8'h01
        |=> blink_phase_reg != $past(blink_phase_reg))
        else $error("blink phase did not flip at period end");
endmodule

// >>> tb/tb.sv
// register and pixel path testbench for the attribute controller
`timescale 1ns/1ns
module tb
    import vgaac_pkg::*;
;
    logic sys_clk = 1'b0, rst_b = 1'b0;
    logic [15:0] io_addr;
    logic io_wr, io_rd, status_one_rd;
    logic [7:0] io_wdata, io_rdata, pix_data = 8'h00, cix, v;
    logic [1:0] status_mux_bits;
    logic [3:0] pan_shift;
    logic pix_valid = 1'b0, pix_ready, pix_active = 1'b1;
    logic pix_top_half = 1'b1, color_valid, color_ready = 1'b0;
    logic [7:0] color_index;
    logic [1:0] blink_rate_code = 2'h0;
    logic pix_line_gfx_col = 1'b0, pix_cursor_on = 1'b0, frame_start = 1'b0;
    int errors = 0, checks = 0, n, k;

    always #2 sys_clk = ~sys_clk;

    vgaac_host host (.sys_clk, .io_addr, .io_wr, .io_rd, .io_wdata,
                     .status_one_rd, .io_rdata);
    vgaac_top dut (.sys_clk, .rst_b, .io_addr, .io_wr, .io_rd, .io_wdata,
        .status_one_rd, .io_rdata, .status_mux_bits,
        .blink_rate_code, .pix_valid, .pix_ready, .pix_data,
        .pix_active, .pix_top_half, .pix_line_gfx_col,
        .pix_cursor_on, .frame_start, .color_valid,
        .color_ready, .color_index, .pan_shift);

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic fail();
        errors++;
        $display("[ERR] %0t wait ran out", $time);
        finish_test();
    endtask

    task automatic set_reg(input logic [4:0] i, input logic [7:0] d,
                           input logic s);
        host.sync();
        host.wr(VGAAC_IDX_PORT, {2'b00, s, i});
        host.wr(VGAAC_IDX_PORT, d);
    endtask

    // leaves the palette source on the processor side
    task automatic chk_reg(input logic [4:0] i, input logic [7:0] e);
        host.sync();
        host.wr(VGAAC_IDX_PORT, {3'b000, i});
        host.rd(VGAAC_RD_PORT, v);
        chk(v, e);
    endtask

    task automatic push(input logic [7:0] d, input logic a);
        int m;
        @(posedge sys_clk);
        pix_data <= d;
        pix_active <= a;
        pix_valid <= 1'b1;
        // ready is looked at once settled, before the edge that takes it
        @(negedge sys_clk);
        for (m = 0; pix_ready !== 1'b1; m++) begin
            if (m == 50) fail();
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        pix_valid <= 1'b0;
        pix_data <= ~d;
    endtask

    task automatic pop();
        int m;
        for (m = 0; color_valid !== 1'b1; m++) begin
            if (m == 50) fail();
            @(negedge sys_clk);
        end
        cix = color_index;
        @(posedge sys_clk);
        color_ready <= 1'b1;
        @(posedge sys_clk);
        color_ready <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic px(input logic [7:0] d, input logic a);
        push(d, a);
        pop();
    endtask

    // one-cycle frame pulses advance the blink timer
    task automatic frames(input int f);
        repeat (f) begin
            @(posedge sys_clk);
            frame_start <= 1'b1;
            @(posedge sys_clk);
            frame_start <= 1'b0;
        end
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (k = 16; k <= 20; k++)
            chk_reg(5'(k), 8'h00);
        $display("test reset done");
        set_reg(VGAAC_MODE_IDX, 8'hff, 1'b0);
        chk_reg(VGAAC_MODE_IDX, 8'hef);
        set_reg(5'h15, 8'hff, 1'b0);
        chk_reg(5'h15, 8'h00);
        set_reg(5'h0f, 8'hea, 1'b0);
        chk_reg(5'h0f, 8'h2a);
        set_reg(5'h03, 8'h05, 1'b0);
        set_reg(5'h03, 8'h3f, 1'b1);
        chk_reg(5'h03, 8'h05);
        host.sync();
        host.wr(VGAAC_IDX_PORT, 8'h11);
        host.wr(VGAAC_IDX_PORT, 8'h5a);
        host.wr(VGAAC_IDX_PORT, 8'h14);
        host.wr(VGAAC_IDX_PORT, 8'h0c);
        chk_reg(VGAAC_BORDER_IDX, 8'h5a);
        chk_reg(VGAAC_CSEL_IDX, 8'h0c);
        host.sync();
        host.wr(VGAAC_IDX_PORT, 8'h33);
        host.rd(VGAAC_IDX_PORT, v);
        chk(v, 8'h33);
        $display("test registers done");
        set_reg(VGAAC_MODE_IDX, 8'h01, 1'b1);
        set_reg(VGAAC_PLANE_IDX, 8'h0f, 1'b1);
        set_reg(VGAAC_PAN_IDX, 8'h03, 1'b1);
        px(8'h0f, 1'b1);
        chk(cix, 8'hea);
        chk({4'h0, pan_shift}, 8'h03);
        // pairs are equal bits so bit order inside a pair cannot matter
        for (k = 0; k < 4; k++) begin
            set_reg(VGAAC_PLANE_IDX, {2'b00, 2'(k), 4'hf}, 1'b1);
            px(8'h03, 1'b1);
            chk(cix, 8'hc5);
            chk({6'h00, status_mux_bits},
                (k % 3 == 0) ? 8'h03 : 8'h00);
        end
        set_reg(VGAAC_PLANE_IDX, 8'h03, 1'b1);
        px(8'h0f, 1'b1);
        chk(cix, 8'hc5);
        px(8'h00, 1'b0);
        chk(cix, 8'h5a);
        $display("test colour path done");
        set_reg(VGAAC_MODE_IDX, 8'h21, 1'b1);
        @(posedge sys_clk);
        pix_top_half <= 1'b0;
        px(8'h03, 1'b1);
        chk({4'h0, pan_shift}, 8'h00);
        @(posedge sys_clk);
        pix_top_half <= 1'b1;
        px(8'h03, 1'b1);
        chk({4'h0, pan_shift}, 8'h03);
        set_reg(VGAAC_PAN_IDX, 8'h09, 1'b1);
        px(8'h03, 1'b1);
        chk({4'h0, pan_shift}, 8'h00);
        set_reg(VGAAC_MODE_IDX, 8'h41, 1'b1);
        set_reg(VGAAC_PAN_IDX, 8'h04, 1'b1);
        px(8'h03, 1'b1);
        chk({4'h0, pan_shift}, 8'h02);
        set_reg(VGAAC_CSEL_IDX, 8'h0f, 1'b1);
        set_reg(VGAAC_MODE_IDX, 8'h81, 1'b1);
        px(8'h03, 1'b1);
        chk(cix, 8'hf5);
        $display("test pan and override done");
        // output side stalls while the buffer fills up
        set_reg(VGAAC_CSEL_IDX, 8'h0c, 1'b1);
        set_reg(VGAAC_MODE_IDX, 8'h01, 1'b1);
        set_reg(VGAAC_PLANE_IDX, 8'h0f, 1'b1);
        for (n = 0; n < 40; n++) begin
            @(negedge sys_clk);
            if (pix_ready !== 1'b1)
                break;
            push(n[0] ? 8'h0f : 8'h03, 1'b1);
        end
        chk(8'(n >= 16 && n < 40), 8'h01);
        for (k = 0; k < n; k++) begin
            pop();
            chk(cix, k[0] ? 8'hea : 8'hc5);
        end
        chk({7'h00, color_valid}, 8'h00);
        $display("test buffer done");
        set_reg(VGAAC_MODE_IDX, 8'h00, 1'b1);
        @(posedge sys_clk);
        pix_cursor_on <= 1'b1;
        pix_line_gfx_col <= 1'b1;
        px(8'h1f, 1'b1);
        chk(cix, 8'hc0);
        set_reg(VGAAC_MODE_IDX, 8'h04, 1'b1);
        px(8'h1f, 1'b1);
        chk(cix, 8'hea);
        @(posedge sys_clk);
        pix_cursor_on <= 1'b0;
        pix_line_gfx_col <= 1'b0;
        px(8'hf3, 1'b1);
        chk(cix, 8'hea);
        set_reg(VGAAC_MODE_IDX, 8'h08, 1'b1);
        px(8'hf3, 1'b1);
        chk(cix, 8'hc0);
        @(posedge sys_clk);
        pix_cursor_on <= 1'b1;
        // 16 frames at code 0 flip the phase; code 1 needs 32
        for (k = 0; k < 4; k++) begin
            px(8'h8f, 1'b1);
            chk(cix, (k == 0 || k == 3) ? 8'hea : 8'hc0);
            @(posedge sys_clk);
            blink_rate_code <= {1'b0, k != 0};
            frames(16);
        end
        $display("test text and blink done");
        finish_test();
    end
endmodule

// >>> tb/vgaac_host.sv
// host processor model for the shared index/data i/o locations
`timescale 1ns/1ns
module vgaac_host (
    // clock
    input  wire logic        sys_clk,
    // legacy i/o bus
    output logic      [15:0] io_addr,
    output logic             io_wr,
    output logic             io_rd,
    output logic      [7:0]  io_wdata,
    output logic             status_one_rd,
    input  wire logic [7:0]  io_rdata
);
    initial begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
        status_one_rd = 1'b0;
    end

    // status read first so the next write is an index write
    task automatic sync();
        @(posedge sys_clk);
        status_one_rd <= 1'b1;
        @(posedge sys_clk);
        status_one_rd <= 1'b0;
    endtask

    // one location takes index and data in turn
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge sys_clk);
        io_wr <= 1'b0;
        // released lines show garbage, not the last value
        io_addr <= ~a;
        io_wdata <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        io_addr <= ~a;
        @(posedge sys_clk);
        #1 d = io_rdata;
    endtask
endmodule
